// ==== hw/pms_supervisor.sv ====
// power-mode supervisor: reset supervision, watchdog, sleep/wake sequencing,
// real-time counter and deep sleep memory
// assumes nrst is the internal power-on reset; all other pins are asynchronous
`timescale 1ns/1ns
`include "pms_params.svh"
// Function
// - hold chip reset from power-up until every monitored supply is good
// - any monitored supply losing power-good forces reset, then a cold restart
// - external reset pin may float; internal power-on reset suffices
// - watchdog is a 16-bit millisecond counter, 1 ms to about 65 s
// - watchdog expiry without rewrite resets the whole chip
// - a readable flag tells whether the last reset came from the watchdog
// - watchdog counts only while AWAKE, frozen otherwise
// - real-time counter never affects the watchdog; watchdog expiry clears the counter through chip reset
// - sleep request or USB standby starts the AWAKE to ASLEEP walk
// - wake stimuli act only in ASLEEP
// - wake seen during the sleep walk is remembered until ASLEEP
// - wake pin edge of programmed polarity wakes the chip
// - real-time counter reaching the compare value wakes the chip
// - real-time counter adds one per main tick while awake
// - counter may switch to the slow oscillator while asleep
// - slow ticks add a programmed increment to keep main-clock time
// - node and peripherals are powered down while ASLEEP
// - deep sleep memory keeps its contents throughout ASLEEP
// - failure of a monitored supply during either transition issues a full reset
module pms_supervisor import pms_pkg::*; #(
  parameter int NSUP = `PMS_NUM_SUPPLIES,
  parameter int DSM_BYTES = `PMS_DSM_BYTES,
  parameter int MS_CYCLES = `PMS_MS_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // pins
  input wire logic ext_rst_n,
  input wire logic [NSUP-1:0] supply_good,
  input wire logic wake_pin,
  input wire logic slow_osc,
  // sleep and wake requests
  input wire logic sleep_req,
  input wire logic usb_standby_req,
  input wire logic usb_wakeup_req,
  // sleep configuration
  input wire logic [NSUP-1:0] cfg_sleep_supply_keep,
  input wire logic cfg_sleep_pulse_skip,
  input wire logic cfg_sleep_clk_mask,
  input wire logic cfg_sleep_assert_reset,
  // wake and counter configuration
  input wire logic cfg_wake_pin_en,
  input wire logic cfg_wake_pin_pol,
  input wire logic cfg_wake_timer_en,
  input wire logic cfg_rtc_slow_en,
  input wire logic [31:0] cfg_rtc_slow_incr,
  input wire logic [63:0] cfg_rtc_compare,
  // watchdog
  input wire logic wdog_load,
  input wire logic [15:0] wdog_timeout,
  // deep sleep memory
  input wire logic dsm_we,
  input wire logic [$clog2(DSM_BYTES)-1:0] dsm_addr,
  input wire logic [7:0] dsm_wdata,
  output logic [7:0] dsm_rdata,
  // reset and power outputs
  output logic chip_rst_n,
  output logic node_rst_n,
  output logic node_power_en,
  output logic periph_power_en,
  output logic [NSUP-1:0] supply_en,
  output logic pulse_skip_supply_mode,
  output logic clk_mask,
  // status
  output logic wdog_reset_seen,
  output pms_state_type power_state,
  output logic [63:0] rtc_count
);
  typedef struct packed {
    logic [NSUP-1:0] good_m;
    logic [NSUP-1:0] good_s;
    logic [NSUP-1:0] supply_en;
    logic [NSUP-1:0] mon;
    logic pin_m;
    logic pin_s;
    logic pin_d;
    logic osc_m;
    logic osc_s;
    logic osc_d;
    logic xrst_m;
    logic xrst_s;
    logic [7:0] hold_cnt;
    logic [7:0] step_cnt;
    logic rst_n;
    logic wdog_flag;
    logic wake_pend;
    logic node_pwr;
    logic clk_mask;
    logic pskip;
    logic node_rst_n;
    pms_state_type state;
    logic [DSM_BYTES-1:0][7:0] dsm;
    logic [7:0] dsm_rdata;
  } pms_sup_state_type;

  pms_sup_state_type s_q, s_d;

  logic wd_expire;
  logic rtc_match;
  logic pwr_fail;
  logic xrst;
  logic rst_cause;
  logic sys_clr;
  logic pin_edge;
  logic wake_ev;
  logic step_done;
  logic sleep_side;

  // true for states where a wake stimulus is held for later
  function automatic logic wake_held(input pms_state_type st);
    return st inside {PMS_SLP_CLK_MASK, PMS_SLP_RESET, PMS_SLP_POWER_DOWN, PMS_ASLEEP};
  endfunction

  // reset causes; only supplies currently switched on are monitored
  assign pwr_fail = |(s_q.mon & ~s_q.good_s);
  assign xrst = ~s_q.xrst_s; // floating pin reads high through its pull-up
  assign rst_cause = pwr_fail | xrst | wd_expire;
  assign sys_clr = ~s_q.rst_n;

  // wake sources; pin and timer qualified by configuration, usb wake always taken
  assign pin_edge = cfg_wake_pin_pol ? (s_q.pin_s & ~s_q.pin_d)
                                     : (~s_q.pin_s & s_q.pin_d);
  assign wake_ev = (pin_edge & cfg_wake_pin_en) | (rtc_match & cfg_wake_timer_en)
                 | usb_wakeup_req;
  assign step_done = (s_q.step_cnt == 8'h0);
  assign sleep_side = wake_held(s_q.state);

  always_comb begin
    s_d = s_q;
    // synchronisers; first stages feed only the second
    s_d.good_m = supply_good;
    s_d.good_s = s_q.good_m;
    s_d.pin_m = wake_pin;
    s_d.pin_s = s_q.pin_m;
    s_d.pin_d = s_q.pin_s;
    s_d.osc_m = slow_osc;
    s_d.osc_s = s_q.osc_m;
    s_d.osc_d = s_q.osc_s;
    s_d.xrst_m = ext_rst_n;
    s_d.xrst_s = s_q.xrst_m;

    // chip reset held while a cause stands, then stretched
    if (rst_cause) begin
      s_d.hold_cnt = `PMS_RST_HOLD_CYCLES;
      s_d.rst_n = 1'b0;
    end else if (s_q.hold_cnt != 8'h0) begin
      s_d.hold_cnt = s_q.hold_cnt - 8'h1;
    end else begin
      s_d.rst_n = 1'b1;
    end

    // last-reset flag: watchdog sets it and wins a tie, power or pin reset clears it
    if (wd_expire) begin
      s_d.wdog_flag = 1'b1;
    end else if (pwr_fail || xrst) begin
      s_d.wdog_flag = 1'b0;
    end

    // step counter runs down inside each transition state
    if (!step_done) begin
      s_d.step_cnt = s_q.step_cnt - 8'h1;
    end

    // wake memory: set wins; dropped once off the sleep side, so a standing
    // timer match cannot carry a stale wake back into AWAKE
    if (sleep_side && wake_ev) begin
      s_d.wake_pend = 1'b1;
    end else if (!sleep_side || s_q.state == PMS_ASLEEP) begin
      s_d.wake_pend = 1'b0;
    end

    if (sys_clr) begin
      // cold start: everything but the memory and the watchdog flag returns to its power-up value
      s_d.state = PMS_AWAKE;
      s_d.supply_en = '1;
      s_d.mon = '1;
      s_d.node_pwr = 1'b1;
      s_d.clk_mask = 1'b0;
      s_d.pskip = 1'b0;
      s_d.node_rst_n = 1'b1;
      s_d.wake_pend = 1'b0;
      s_d.step_cnt = 8'h0;
    end else begin
      // fixed-order walk, reversed on wake, each step after its settle count
      unique case (s_q.state)
        PMS_AWAKE: begin
          if (sleep_req || usb_standby_req) begin
            s_d.state = PMS_SLP_CLK_MASK;
            s_d.step_cnt = `PMS_STEP_CYCLES;
            s_d.clk_mask = cfg_sleep_clk_mask;
          end
        end
        PMS_SLP_CLK_MASK: begin
          if (step_done) begin
            s_d.state = PMS_SLP_RESET;
            s_d.step_cnt = `PMS_STEP_CYCLES;
            s_d.node_rst_n = ~cfg_sleep_assert_reset;
          end
        end
        PMS_SLP_RESET: begin
          if (step_done) begin
            s_d.state = PMS_SLP_POWER_DOWN;
            s_d.step_cnt = `PMS_STEP_CYCLES;
            s_d.node_pwr = 1'b0;
            s_d.supply_en = cfg_sleep_supply_keep;
            s_d.mon = cfg_sleep_supply_keep; // switched-off supplies stop counting as failures
            s_d.pskip = cfg_sleep_pulse_skip;
          end
        end
        PMS_SLP_POWER_DOWN: begin
          if (step_done) begin
            s_d.state = PMS_ASLEEP;
          end
        end
        PMS_ASLEEP: begin
          if (s_q.wake_pend) begin
            s_d.state = PMS_WK_POWER_UP;
            s_d.step_cnt = `PMS_STEP_CYCLES;
            s_d.supply_en = '1;
            s_d.pskip = 1'b0;
          end
        end
        PMS_WK_POWER_UP: begin
          // no timeout: a supply that never comes good leaves the chip here
          if (step_done && (&s_q.good_s)) begin
            s_d.state = PMS_WK_RESET_RELEASE;
            s_d.step_cnt = `PMS_STEP_CYCLES;
            s_d.mon = '1;
            s_d.node_pwr = 1'b1;
          end
        end
        PMS_WK_RESET_RELEASE: begin
          if (step_done) begin
            s_d.state = PMS_WK_CLK_UNMASK;
            s_d.step_cnt = `PMS_STEP_CYCLES;
            s_d.node_rst_n = 1'b1;
          end
        end
        PMS_WK_CLK_UNMASK: begin
          if (step_done) begin
            s_d.state = PMS_AWAKE;
            s_d.clk_mask = 1'b0;
          end
        end
      endcase
    end

    // deep sleep memory: kept through sleep and chip resets, lost only on nrst
    if (dsm_we && s_q.state == PMS_AWAKE && s_q.rst_n) begin
      s_d.dsm[dsm_addr] = dsm_wdata;
    end
    s_d.dsm_rdata = s_q.dsm[dsm_addr];
  end

  // power-on reset holds chip reset asserted with all supplies on
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
      s_q.supply_en <= '1;
      s_q.mon <= '1;
      s_q.node_pwr <= 1'b1;
      s_q.node_rst_n <= 1'b1;
      s_q.xrst_m <= 1'b1;
      s_q.xrst_s <= 1'b1;
      s_q.hold_cnt <= `PMS_RST_HOLD_CYCLES;
    end else begin
      s_q <= s_d;
    end
  end

  // watchdog counts only in AWAKE, out of reset
  pms_watchdog #(
    .MS_CYCLES(MS_CYCLES)
  ) u_wdog (
    .clk(clk),
    .nrst(nrst),
    .clr(sys_clr),
    .run(s_q.state == PMS_AWAKE && s_q.rst_n),
    .load(wdog_load && s_q.rst_n),
    .timeout(wdog_timeout),
    .expire(wd_expire)
  );

  // slow mode only in ASLEEP and only when enabled
  pms_rtc u_rtc (
    .clk(clk),
    .nrst(nrst),
    .clr(sys_clr),
    .slow_mode(cfg_rtc_slow_en && s_q.state == PMS_ASLEEP),
    .slow_tick(s_q.osc_s && !s_q.osc_d),
    .incr(cfg_rtc_slow_incr),
    .compare(cfg_rtc_compare),
    .count(rtc_count),
    .match(rtc_match)
  );

  // outputs straight from state flops
  assign chip_rst_n = s_q.rst_n;
  assign node_rst_n = s_q.node_rst_n;
  assign node_power_en = s_q.node_pwr;
  assign periph_power_en = s_q.node_pwr;
  assign supply_en = s_q.supply_en;
  assign pulse_skip_supply_mode = s_q.pskip;
  assign clk_mask = s_q.clk_mask;
  assign wdog_reset_seen = s_q.wdog_flag;
  assign power_state = s_q.state;
  assign dsm_rdata = s_q.dsm_rdata;

  AST_PWR_FAIL_RESET: assert property (@(posedge clk) disable iff (!nrst)
    pwr_fail |=> !s_q.rst_n [*2])
    else $error("supply failure did not hold reset");

  AST_POR_HOLD: assert property (@(posedge clk) disable iff (!nrst)
    !s_q.rst_n && s_q.hold_cnt != 8'h0 |=> !s_q.rst_n)
    else $error("reset released before hold count ran out");

  AST_WDOG_RESET: assert property (@(posedge clk) disable iff (!nrst)
    wd_expire && !pwr_fail && !xrst |=> s_q.wdog_flag && !s_q.rst_n)
    else $error("watchdog expiry did not reset and flag");

  AST_SLEEP_ENTRY: assert property (@(posedge clk) disable iff (!nrst)
    s_q.state == PMS_AWAKE && s_q.rst_n && !rst_cause && (sleep_req || usb_standby_req)
    |=> s_q.state == PMS_SLP_CLK_MASK)
    else $error("sleep request not taken");

  AST_AWAKE_IGNORES_WAKE: assert property (@(posedge clk) disable iff (!nrst)
    s_q.state == PMS_AWAKE && !sleep_req && !usb_standby_req |=> s_q.state == PMS_AWAKE
    && !s_q.wake_pend)
    else $error("awake controller reacted to wake");

  AST_WAKE_REMEMBERED: assert property (@(posedge clk) disable iff (!nrst)
    s_q.state == PMS_SLP_RESET && s_q.rst_n && !rst_cause && wake_ev |=> s_q.wake_pend)
    else $error("wake during sleep walk lost");

  AST_ASLEEP_POWER: assert property (@(posedge clk) disable iff (!nrst)
    s_q.state == PMS_ASLEEP |-> !node_power_en && !periph_power_en)
    else $error("node powered while asleep");

endmodule // pms_supervisor

// ==== include/pms_params.svh ====
// constants for the power-mode supervisor: timing, reset values, sizes
// assumes a 10 MHz system clock; included by the supervisor design files
`ifndef PMS_PARAMS_SVH
`define PMS_PARAMS_SVH

// clock period and the watchdog's one-millisecond tick
`define PMS_CLK_PERIOD_NS 100
`define PMS_MS_NS 1000000
`define PMS_MS_CYCLES (`PMS_MS_NS / `PMS_CLK_PERIOD_NS)

// watchdog timeout after a cold start, in ms
`define PMS_WDOG_RESET_TIMEOUT 16'hffff

// settling cycles of each transition step, and reset stretch after a cause clears
`define PMS_STEP_CYCLES 8'h08
`define PMS_RST_HOLD_CYCLES 8'h10

// supply count, deep sleep memory size, index of the second buck supply
`define PMS_NUM_SUPPLIES 4
`define PMS_DSM_BYTES 128
`define PMS_SECOND_BUCK_IDX 1

`endif

// ==== include/pms_pkg.sv ====
// types shared by the power-mode supervisor modules
// assumes pms_params.svh is included by each design file
package pms_pkg;

  // power controller states; transition steps run in this order and back
  typedef enum logic [2:0] {
    PMS_AWAKE,
    PMS_SLP_CLK_MASK,
    PMS_SLP_RESET,
    PMS_SLP_POWER_DOWN,
    PMS_ASLEEP,
    PMS_WK_POWER_UP,
    PMS_WK_RESET_RELEASE,
    PMS_WK_CLK_UNMASK
  } pms_state_type;

endpackage

// ==== hw/pms_watchdog.sv ====
// 16-bit millisecond watchdog with its own prescaler
// assumes run is high only while the power controller is awake
`timescale 1ns/1ns
`include "pms_params.svh"
module pms_watchdog import pms_pkg::*; #(
  parameter int MS_CYCLES = `PMS_MS_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // control
  input wire logic clr,
  input wire logic run,
  input wire logic load,
  input wire logic [15:0] timeout,
  // expiry, one-cycle pulse
  output logic expire
);
  localparam int PW = $clog2(MS_CYCLES + 1);

  typedef struct packed {
    logic [PW-1:0] pre;
    logic [15:0] cnt;
    logic expire;
  } pms_wdog_state_type;

  pms_wdog_state_type w_q, w_d;

  // prescaler and counter run on their own; the real-time counter never touches them
  always_comb begin
    w_d = w_q;
    w_d.expire = 1'b0;
    if (clr) begin
      w_d.pre = '0;
      w_d.cnt = `PMS_WDOG_RESET_TIMEOUT;
    end else if (load) begin
      w_d.pre = '0;
      w_d.cnt = (timeout == 16'h0) ? 16'h1 : timeout; // 1 ms is the floor
    end else if (run) begin
      if (w_q.pre == PW'(MS_CYCLES - 1)) begin
        w_d.pre = '0;
        if (w_q.cnt <= 16'h1) begin
          w_d.expire = 1'b1;
          w_d.cnt = `PMS_WDOG_RESET_TIMEOUT;
        end else begin
          w_d.cnt = w_q.cnt - 16'h1;
        end
      end else begin
        w_d.pre = w_q.pre + PW'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      w_q <= '0;
    end else begin
      w_q <= w_d;
    end
  end

  assign expire = w_q.expire;

  AST_WDOG_FREEZE: assert property (@(posedge clk) disable iff (!nrst)
    !run && !load && !clr |=> $stable(w_q.cnt) && $stable(w_q.pre))
    else $error("watchdog moved while frozen");

endmodule // pms_watchdog

// ==== hw/pms_rtc.sv ====
// 64-bit real-time counter with fast and slow tick modes and compare match
// assumes slow_tick is an already synchronised one-cycle pulse
`timescale 1ns/1ns
`include "pms_params.svh"
module pms_rtc import pms_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // control
  input wire logic clr,
  input wire logic slow_mode,
  input wire logic slow_tick,
  input wire logic [31:0] incr,
  input wire logic [63:0] compare,
  // state
  output logic [63:0] count,
  output logic match
);
  typedef struct packed {
    logic [63:0] count;
    logic match;
  } pms_rtc_state_type;

  pms_rtc_state_type r_q, r_d;

  // >= rather than == so a large slow increment cannot step over the compare
  always_comb begin
    r_d = r_q;
    r_d.match = (r_q.count >= compare);
    if (clr) begin
      r_d.count = '0;
    end else if (slow_mode) begin
      if (slow_tick) begin
        r_d.count = r_q.count + {32'h0, incr};
      end
    end else begin
      r_d.count = r_q.count + 64'h1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign count = r_q.count;
  assign match = r_q.match;

  AST_RTC_FAST: assert property (@(posedge clk) disable iff (!nrst)
    !clr && !slow_mode |=> r_q.count == $past(r_q.count) + 64'h1)
    else $error("rtc missed a main tick");

endmodule // pms_rtc

// ==== testbench/pms_partner.sv ====
// far-side model: supply monitors, wake pin, slow oscillator and usb block
// assumes the bench calls its tasks just after a rising clock edge
`timescale 1ns/1ns
module pms_partner #(
  parameter int NSUP = 4,
  parameter int SLOW_HALF_NS = 16000
) (
  // clock and supply enables from the supervisor
  input wire logic clk,
  input wire logic [NSUP-1:0] supply_en,
  // toward the supervisor
  output logic ext_rst_n,
  output logic [NSUP-1:0] supply_good,
  output logic wake_pin,
  output logic slow_osc,
  output logic usb_standby_req,
  output logic usb_wakeup_req
);
  logic [NSUP-1:0] fault = '0;

  // reset pin left floating, the board pull-up keeps it inactive
  assign ext_rst_n = 1'h1;
  initial begin
    wake_pin = 1'h0;
    slow_osc = 1'h0;
    usb_standby_req = 1'h0;
    usb_wakeup_req = 1'h0;
  end
  // a switched-off supply never reports good; one cycle of settling
  always @(posedge clk) begin
    supply_good <= supply_en & ~fault;
  end
  // free-running slow oscillator, phase unrelated to clk
  initial begin
    #7;
    forever #(SLOW_HALF_NS) slow_osc = ~slow_osc;
  end
  // one-cycle usb request pulse
  task automatic usb_pulse(input logic wake);
    usb_wakeup_req = wake;
    usb_standby_req = ~wake;
    @(posedge clk);
    #1;
    usb_wakeup_req = 1'h0;
    usb_standby_req = 1'h0;
  endtask
  task automatic set_fault(input int idx, input logic bad);
    fault[idx] = bad;
  endtask
  task automatic set_wake(input logic lvl);
    wake_pin = lvl;
  endtask
endmodule // pms_partner

// ==== testbench/power_mode_supervisor_tb_top.sv ====
// self-checking bench for the power-mode supervisor
// assumes pms_partner stands for supplies, wake pin, slow oscillator and usb
`timescale 1ns/1ns
module power_mode_supervisor_tb_top;
  import pms_pkg::*;
  typedef struct packed {logic [3:0] sel; logic [63:0] val;} pms_note_type;
  // control inputs, all driven by the bench
  logic clk = 1'h0;
  logic nrst = 1'h0;
  logic sleep_req = 1'h0;
  logic wdog_load = 1'h0;
  logic dsm_we = 1'h0;
  logic pin_en = 1'h0;
  logic slow_en = 1'h0;
  logic timer_en = 1'h0;
  logic sk_cfg = 1'h1, mk_cfg = 1'h1, ar_cfg = 1'h1, pol_cfg = 1'h1;
  logic [3:0] keep = 4'h2;
  logic [31:0] incr = 32'h10;
  logic [63:0] cmpv = '1;
  logic [15:0] wdog_to = 16'hffff;
  logic [6:0] addr = 7'h0;
  logic [7:0] wdata = 8'h0;
  // design outputs and partner lines
  logic ext_rst_n, wake_pin, slow_osc, usb_standby_req, usb_wakeup_req;
  logic chip_rst_n, node_rst_n, node_power_en, periph_power_en, pskip, clk_mask, wdog_seen;
  logic [3:0] supply_good, supply_en;
  logic [7:0] dsm_rdata;
  logic [63:0] rtc_count, r0;
  pms_state_type power_state;
  pms_note_type notes[$];
  pms_note_type n;
  int failures = 0;
  int check_count = 0;
  int i;
  logic [31:0] rng = 32'hb7f734bd;
  string nm[11] = '{"power_state", "chip_rst_n", "wdog_reset_seen", "rtc_count", "dsm_rdata",
                    "node_power_en", "supply_en", "clk_mask", "node_rst_n",
                    "pulse_skip_supply_mode", "periph_power_en"};

  pms_partner partner_u (.clk(clk), .supply_en(supply_en), .ext_rst_n(ext_rst_n),
    .supply_good(supply_good), .wake_pin(wake_pin), .slow_osc(slow_osc),
    .usb_standby_req(usb_standby_req), .usb_wakeup_req(usb_wakeup_req));
  // short watchdog prescale so millisecond timeouts stay cheap
  pms_supervisor #(.MS_CYCLES(10)) dut_u (.clk(clk), .nrst(nrst), .ext_rst_n(ext_rst_n),
    .supply_good(supply_good), .wake_pin(wake_pin), .slow_osc(slow_osc),
    .sleep_req(sleep_req), .usb_standby_req(usb_standby_req), .usb_wakeup_req(usb_wakeup_req),
    .cfg_sleep_supply_keep(keep), .cfg_sleep_pulse_skip(sk_cfg), .cfg_sleep_clk_mask(mk_cfg),
    .cfg_sleep_assert_reset(ar_cfg), .cfg_wake_pin_en(pin_en), .cfg_wake_pin_pol(pol_cfg),
    .cfg_wake_timer_en(timer_en), .cfg_rtc_slow_en(slow_en), .cfg_rtc_slow_incr(incr),
    .cfg_rtc_compare(cmpv), .wdog_load(wdog_load), .wdog_timeout(wdog_to), .dsm_we(dsm_we),
    .dsm_addr(addr), .dsm_wdata(wdata), .dsm_rdata(dsm_rdata), .chip_rst_n(chip_rst_n),
    .node_rst_n(node_rst_n), .node_power_en(node_power_en), .periph_power_en(periph_power_en),
    .supply_en(supply_en), .pulse_skip_supply_mode(pskip), .clk_mask(clk_mask),
    .wdog_reset_seen(wdog_seen), .power_state(power_state), .rtc_count(rtc_count));

  initial forever #50 clk = ~clk;

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  function automatic logic [63:0] seen(input logic [3:0] sel);
    case (sel)
      4'h1: return {63'h0, chip_rst_n};
      4'h2: return {63'h0, wdog_seen};
      4'h3: return rtc_count;
      4'h4: return {56'h0, dsm_rdata};
      4'h5: return {63'h0, node_power_en};
      4'h6: return {60'h0, supply_en};
      4'h7: return {63'h0, clk_mask};
      4'h8: return {63'h0, node_rst_n};
      4'h9: return {63'h0, pskip};
      4'ha: return {63'h0, periph_power_en};
      default: return {61'h0, power_state};
    endcase
  endfunction
  task automatic tally_and_finish();
    if (failures == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic cmp_state(input pms_state_type exp, input pms_state_type got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("BAD power_state expected %s seen %s", exp.name(), got.name());
    end
  endtask
  task automatic cmp_val(input string what, input logic [63:0] exp, input logic [63:0] got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // watcher: each edge settles the values that the oldest note speaks of
  always @(posedge clk) begin
    if (notes.size() > 0) begin
      n = notes.pop_front();
      if (n.sel == 4'h0) begin
        cmp_state(pms_state_type'(n.val[2:0]), power_state);
      end else begin
        cmp_val(nm[n.sel], n.val, seen(n.sel));
      end
    end
  end
  // inputs move 1 ns after the edge, never on it
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic expect_now(input logic [3:0] sel, input logic [63:0] val);
    notes.push_back('{sel, val});
    tick(1);
  endtask
  task automatic wait_until(input logic [3:0] sel, input logic [63:0] val, input int bound);
    for (i = 0; i < bound && seen(sel) !== val; i++) tick(1);
    if (i == bound) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm[sel], val, seen(sel));
      tally_and_finish();
    end
  endtask
  task automatic pulse_load(input logic [15:0] t);
    wdog_to = t;
    wdog_load = 1'h1;
    tick(1);
    wdog_load = 1'h0;
  endtask
  task automatic pulse_sleep();
    sleep_req = 1'h1;
    tick(1);
    sleep_req = 1'h0;
  endtask

  initial begin
    #1;
    partner_u.set_fault(2, 1'h1);
    tick(16);
    nrst = 1'h1;
    // one supply still bad: chip held in reset with the reset pin floating
    tick(40);
    expect_now(4'h1, 64'h0);
    partner_u.set_fault(2, 1'h0);
    wait_until(4'h1, 64'h1, 30);
    // counter runs one per clock, untouched by a watchdog reload
    r0 = rtc_count;
    pulse_load(16'hffff);
    tick(4);
    expect_now(4'h3, r0 + 64'h5);
    rng = xorshift(rng);
    addr = rng[6:0];
    wdata = rng[15:8];
    {sk_cfg, mk_cfg, ar_cfg} = rng[18:16];
    dsm_we = 1'h1;
    tick(1);
    dsm_we = 1'h0;
    // usb standby, resume arriving mid-walk; every step in order
    partner_u.usb_pulse(1'h0);
    for (int k = 1; k < 8; k++) begin
      wait_until(4'h0, 64'(k), 12);
      if (k == 1) expect_now(4'h7, {63'h0, mk_cfg});
      if (k == 2) expect_now(4'h8, {63'h0, ~ar_cfg});
      if (k == 2) partner_u.usb_pulse(1'h1);
      if (k == 3) expect_now(4'h6, {60'h0, keep});
      if (k == 3) expect_now(4'h9, {63'h0, sk_cfg});
      if (k == 4) expect_now(4'h5, 64'h0);
      if (k == 4) expect_now(4'ha, 64'h0);
    end
    wait_until(4'h0, 64'(PMS_AWAKE), 12);
    expect_now(4'h4, {56'h0, wdata});
    expect_now(4'h7, 64'h0);
    expect_now(4'h8, 64'h1);
    // watchdog: reload restarts, expiry resets and is flagged
    pulse_load(16'h0003);
    tick(25);
    expect_now(4'h1, 64'h1);
    pulse_load(16'h0003);
    tick(25);
    expect_now(4'h1, 64'h1);
    wait_until(4'h1, 64'h0, 12);
    wait_until(4'h1, 64'h1, 30);
    expect_now(4'h2, 64'h1);
    // wake in awake ignored; short watchdog frozen through sleep; slow ticks
    rng = xorshift(rng);
    pol_cfg = rng[16];
    partner_u.set_wake(~pol_cfg); // pin parked at its inactive level while still awake
    partner_u.usb_pulse(1'h1);
    pin_en = 1'h1;
    slow_en = 1'h1;
    incr = {16'h0, rng[15:0]} | 32'h100;
    {sk_cfg, mk_cfg, ar_cfg} = 3'h7;
    pulse_load(16'h0001);
    pulse_sleep();
    wait_until(4'h0, 64'(PMS_ASLEEP), 40);
    tick(20);
    expect_now(4'h0, 64'(PMS_ASLEEP));
    expect_now(4'h1, 64'h1);
    expect_now(4'h9, 64'h1);
    expect_now(4'h8, 64'h0);
    r0 = rtc_count;
    for (i = 0; i < 400 && rtc_count === r0; i++) tick(1);
    expect_now(4'h3, r0 + {32'h0, incr});
    partner_u.set_wake(pol_cfg);
    wait_until(4'h0, 64'(PMS_WK_POWER_UP), 8);
    // supply lost during the wake walk: full cold reset
    wait_until(4'h0, 64'(PMS_WK_CLK_UNMASK), 30);
    partner_u.set_fault(0, 1'h1);
    wait_until(4'h1, 64'h0, 8);
    tick(2);
    expect_now(4'h0, 64'(PMS_AWAKE));
    partner_u.set_fault(0, 1'h0);
    wait_until(4'h1, 64'h1, 30);
    expect_now(4'h2, 64'h0);
    // timer wake: asleep just before the compare, wake walk started right after it, then awake
    pin_en = 1'h0;
    slow_en = 1'h0;
    timer_en = 1'h1;
    cmpv = rtc_count + 64'h00c8;
    pulse_sleep();
    wait_until(4'h3, cmpv - 64'h4, 300);
    expect_now(4'h0, 64'(PMS_ASLEEP));
    wait_until(4'h0, 64'(PMS_WK_POWER_UP), 10);
    wait_until(4'h0, 64'(PMS_AWAKE), 40);
    tick(2);
    tally_and_finish();
  end
endmodule // power_mode_supervisor_tb_top
